//--- design/backlight_cfg_pkg.sv
`default_nettype none
package backlight_cfg_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int CODE_W = 11;
   localparam int CODE_LOW_W = 3;
   localparam int FAULT_CTRL_W = 4;
   localparam int FLAG_W = 5;

   // register offsets
   localparam logic [ADDR_W-1:0] OFS_PWM_CTRL = 8'h12;
   localparam logic [ADDR_W-1:0] OFS_BOOST_CTRL = 8'h13;
   localparam logic [ADDR_W-1:0] OFS_AF_UPPER = 8'h15;
   localparam logic [ADDR_W-1:0] OFS_AF_LOWER = 8'h16;
   localparam logic [ADDR_W-1:0] OFS_CEILING = 8'h17;
   localparam logic [ADDR_W-1:0] OFS_CODE_LOW = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_CODE_HIGH = 8'h19;
   localparam logic [ADDR_W-1:0] OFS_FAULT_CTRL = 8'h1e;
   localparam logic [ADDR_W-1:0] OFS_FAULT_FLAGS = 8'h1f;

   // reset values
   localparam logic [DATA_W-1:0] PWM_CTRL_RST = 8'h73;
   localparam logic [DATA_W-1:0] BOOST_CTRL_RST = 8'h6f;
   localparam logic [DATA_W-1:0] BOOST_CTRL_WMASK = 8'h7f;
   localparam logic [DATA_W-1:0] AF_UPPER_RST = 8'h00;
   localparam logic [DATA_W-1:0] AF_LOWER_RST = 8'h00;
   localparam logic [DATA_W-1:0] CEILING_RST = 8'h00;
   localparam logic [CODE_LOW_W-1:0] CODE_LOW_RST = 3'h7;
   localparam logic [DATA_W-1:0] CODE_HIGH_RST = 8'hff;
   localparam logic [FAULT_CTRL_W-1:0] FAULT_CTRL_RST = 4'h7;
   localparam logic [FLAG_W-1:0] FLAGS_RST = 5'h00;
   localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;

   // pwm control fields
   localparam int PWM_RATE_HI = 7;
   localparam int PWM_RATE_LO = 6;
   localparam int PWM_POL_BIT = 5;
   localparam int PWM_HYST_HI = 4;
   localparam int PWM_HYST_LO = 2;
   localparam int PWM_FILT_HI = 1;
   localparam int PWM_FILT_LO = 0;
   localparam logic [2:0] HYST_INVALID = 3'h7;

   // boost control fields
   localparam int BOOST_SHIFT_BIT = 6;
   localparam int BOOST_FREQ_BIT = 5;
   localparam int BOOST_IND_BIT = 4;
   localparam int BOOST_OVP_HI = 3;
   localparam int BOOST_OVP_LO = 2;
   localparam int BOOST_ILIM_HI = 1;
   localparam int BOOST_ILIM_LO = 0;

   // fault control and flag fields
   localparam int FC_SHORT_EN_BIT = 3;
   localparam int FC_TSD_BIT = 2;
   localparam int FC_ILIM_BIT = 1;
   localparam int FC_OVP_BIT = 0;
   localparam int FLAG_OPEN_BIT = 4;
   localparam int FLAG_SHORT_BIT = 3;
   localparam int FLAG_TSD_BIT = 2;
   localparam int FLAG_ILIM_BIT = 1;
   localparam int FLAG_OVP_BIT = 0;

   typedef enum logic [1:0] {RATE_800K, RATE_4M, RATE_24M} sample_rate_t;
   typedef enum logic [1:0] {FREQ_250K, FREQ_500K, FREQ_1000K} switch_freq_t;

   function automatic logic reaches(input logic [DATA_W-1:0] level, input logic [DATA_W-1:0] thr);
      reaches = (level >= thr);
   endfunction : reaches
endpackage : backlight_cfg_pkg
`default_nettype wire

//--- design/fault_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface fault_link_if;
   import backlight_cfg_pkg::*;
   logic [FAULT_CTRL_W-1:0] ctrl;
   logic [FLAG_W-1:0] raw;
   logic flags_read;
   logic [FLAG_W-1:0] flags;
   logic shutdown;
   modport regs (output ctrl, output raw, output flags_read, input flags, input shutdown);
   modport monitor (input ctrl, input raw, input flags_read, output flags, output shutdown);
endinterface : fault_link_if
`default_nettype wire

//--- design/fault_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module fault_monitor (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // fault link to register bank
   fault_link_if.monitor link
);
   import backlight_cfg_pkg::*;

   logic [FLAG_W-1:0] events;
   logic [FLAG_W-1:0] trip_mask;
   logic [FLAG_W-1:0] next_flags;
   logic next_shutdown;

   always_comb
   begin
      events = link.raw;
      events[FLAG_SHORT_BIT] = link.raw[FLAG_SHORT_BIT] & link.ctrl[FC_SHORT_EN_BIT];
      // a zero control bit arms shutdown; open string shares the overvoltage control
      trip_mask = '0;
      trip_mask[FLAG_OVP_BIT] = ~link.ctrl[FC_OVP_BIT];
      trip_mask[FLAG_OPEN_BIT] = ~link.ctrl[FC_OVP_BIT];
      trip_mask[FLAG_ILIM_BIT] = ~link.ctrl[FC_ILIM_BIT];
      trip_mask[FLAG_TSD_BIT] = ~link.ctrl[FC_TSD_BIT];
      // set wins over the clear-on-read so no event is lost
      next_flags = (link.flags & ~{FLAG_W{link.flags_read}}) | events;
      if (|(events & trip_mask))
         next_shutdown = 1'b1;
      else if (link.flags_read)
         next_shutdown = 1'b0;
      else
         next_shutdown = link.shutdown;
   end

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         link.flags <= FLAGS_RST;
         link.shutdown <= 1'b0;
      end
      else
      begin
         link.flags <= next_flags;
         link.shutdown <= next_shutdown;
      end
   end
endmodule : fault_monitor
`default_nettype wire

//--- design/brightness_path.sv
`timescale 1ns/1ps
`default_nettype none
module brightness_path (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // settings
   input wire logic [backlight_cfg_pkg::DATA_W-1:0] code_high,
   input wire logic [backlight_cfg_pkg::CODE_LOW_W-1:0] code_low,
   input wire logic [backlight_cfg_pkg::DATA_W-1:0] ceiling,
   input wire logic [backlight_cfg_pkg::DATA_W-1:0] af_upper,
   input wire logic [backlight_cfg_pkg::DATA_W-1:0] af_lower,
   input wire logic brightness_ceiling_input,
   // results
   output logic [backlight_cfg_pkg::CODE_W-1:0] code_out,
   output backlight_cfg_pkg::switch_freq_t freq_sel
);
   import backlight_cfg_pkg::*;

   logic [DATA_W-1:0] upper;
   logic [CODE_W-1:0] next_code_out;
   switch_freq_t next_freq_sel;

   always_comb
   begin
      upper = brightness_ceiling_input ? ceiling : code_high;
      next_code_out = {upper, code_low};
      // high threshold checked first so it takes priority
      if (reaches(upper, af_upper))
         next_freq_sel = FREQ_1000K;
      else if (reaches(upper, af_lower))
         next_freq_sel = FREQ_500K;
      else
         next_freq_sel = FREQ_250K;
   end

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         code_out <= {CODE_HIGH_RST, CODE_LOW_RST};
         freq_sel <= FREQ_1000K;
      end
      else
      begin
         code_out <= next_code_out;
         freq_sel <= next_freq_sel;
      end
   end
endmodule : brightness_path
`default_nettype wire

//--- design/backlight_driver_config_regs.sv
// Overview of operation
// - pwm control bits 7:6 pick sample rate 800k, 4M, or 24M when bit7 set.
// - pwm control bit 5 sets input sense; one means active high.
// - pwm control bits 4:2 give hysteresis 0..6 steps; 111 invalid.
// - pwm control bits 1:0 pick pulse filter none, 100, 150, 200 ns.
// - boost bit 6 zero applies minus twelve percent shift; bit 7 reserved.
// - boost bit 5 picks 500 kHz when zero, 1 MHz when one.
// - boost bit 4 tells inductor size: 10 uH or 22 uH.
// - boost bits 3:2 pick overvoltage limit 17, 21, 25, 29 V.
// - boost bits 1:0 pick current limit 750 to 1500 mA.
// - upper threshold against upper code bits chooses 500k or 1000k.
// - lower threshold against upper code bits chooses 250k or 500k.
// - ceiling input high forces upper code bits to ceiling register.
// - low brightness register holds three code lsbs, reset 111.
// - high brightness register holds eight code msbs, reset all ones.
// - fault control bit 3 enables led short detection.
// - fault control bits 2:0 zero make matching flag force shutdown.
// - flag register bits: open, short, thermal, current limit, overvoltage.
// - reserved bits and unmapped addresses read as zero.
// - device enable going high restores pwm control to reset value.
`timescale 1ns/1ps
`default_nettype none
module backlight_driver_config_regs (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // register access from the serial host link
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [backlight_cfg_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [backlight_cfg_pkg::DATA_W-1:0] reg_wdata,
   output logic [backlight_cfg_pkg::DATA_W-1:0] reg_rdata,
   // device enable and run state
   input wire logic device_enable,
   output logic device_running,
   output logic fault_shutdown,
   // fault detectors and ceiling pin
   input wire logic output_overvoltage_protect,
   input wire logic switch_current_limit,
   input wire logic thermal_shutdown,
   input wire logic led_open_detect,
   input wire logic led_short_detect,
   input wire logic brightness_ceiling_input,
   // pwm input conditioning settings
   output backlight_cfg_pkg::sample_rate_t pwm_sample_rate,
   output logic pwm_active_high,
   output logic [2:0] pwm_hysteresis_steps,
   output logic [1:0] pwm_filter_sel,
   // boost settings
   output logic boost_no_shift,
   output logic boost_freq_1mhz,
   output logic inductor_22uh,
   output logic [1:0] overvoltage_level,
   output logic [1:0] current_limit_level,
   // brightness results
   output logic [backlight_cfg_pkg::CODE_W-1:0] brightness_code,
   output backlight_cfg_pkg::switch_freq_t auto_freq_sel
);
   import backlight_cfg_pkg::*;

   logic [DATA_W-1:0] pwm_input_control;
   logic [DATA_W-1:0] boost_converter_control;
   logic [DATA_W-1:0] auto_freq_upper_threshold;
   logic [DATA_W-1:0] auto_freq_lower_threshold;
   logic [DATA_W-1:0] brightness_ceiling;
   logic [CODE_LOW_W-1:0] brightness_code_low;
   logic [DATA_W-1:0] brightness_code_high;
   logic [FAULT_CTRL_W-1:0] fault_response_control;
   logic enable_seen;

   logic [DATA_W-1:0] next_pwm_input_control;
   logic [DATA_W-1:0] next_boost_converter_control;
   logic [DATA_W-1:0] next_auto_freq_upper_threshold;
   logic [DATA_W-1:0] next_auto_freq_lower_threshold;
   logic [DATA_W-1:0] next_brightness_ceiling;
   logic [CODE_LOW_W-1:0] next_brightness_code_low;
   logic [DATA_W-1:0] next_brightness_code_high;
   logic [FAULT_CTRL_W-1:0] next_fault_response_control;
   logic [DATA_W-1:0] next_reg_rdata;
   logic next_device_running;
   logic next_fault_shutdown;
   sample_rate_t next_pwm_sample_rate;
   logic enable_rise;

   fault_link_if link ();

   // fault events enter the monitor as levels; it latches them
   assign link.ctrl = fault_response_control;
   assign link.raw = {led_open_detect, led_short_detect, thermal_shutdown, switch_current_limit,
                      output_overvoltage_protect};
   assign link.flags_read = reg_read && (reg_addr == OFS_FAULT_FLAGS);

   fault_monitor faults (
      .clock(clock),
      .resetn(resetn),
      .link(link.monitor)
   );

   brightness_path bright (
      .clock(clock),
      .resetn(resetn),
      .code_high(brightness_code_high),
      .code_low(brightness_code_low),
      .ceiling(brightness_ceiling),
      .af_upper(auto_freq_upper_threshold),
      .af_lower(auto_freq_lower_threshold),
      .brightness_ceiling_input(brightness_ceiling_input),
      .code_out(brightness_code),
      .freq_sel(auto_freq_sel)
   );

   function automatic logic [DATA_W-1:0] readback(input logic [ADDR_W-1:0] addr);
      readback = READ_ZERO;
      unique case (addr)
         OFS_PWM_CTRL: readback = pwm_input_control;
         OFS_BOOST_CTRL: readback = boost_converter_control & BOOST_CTRL_WMASK;
         OFS_AF_UPPER: readback = auto_freq_upper_threshold;
         OFS_AF_LOWER: readback = auto_freq_lower_threshold;
         OFS_CEILING: readback = brightness_ceiling;
         OFS_CODE_LOW: readback[CODE_LOW_W-1:0] = brightness_code_low;
         OFS_CODE_HIGH: readback = brightness_code_high;
         OFS_FAULT_CTRL: readback[FAULT_CTRL_W-1:0] = fault_response_control;
         OFS_FAULT_FLAGS: readback[FLAG_W-1:0] = link.flags;
         default: readback = READ_ZERO;
      endcase
   endfunction : readback

   always_comb
   begin
      enable_rise = device_enable && !enable_seen;
      next_pwm_input_control = pwm_input_control;
      next_boost_converter_control = boost_converter_control;
      next_auto_freq_upper_threshold = auto_freq_upper_threshold;
      next_auto_freq_lower_threshold = auto_freq_lower_threshold;
      next_brightness_ceiling = brightness_ceiling;
      next_brightness_code_low = brightness_code_low;
      next_brightness_code_high = brightness_code_high;
      next_fault_response_control = fault_response_control;
      if (reg_write)
      begin
         unique case (reg_addr)
            OFS_PWM_CTRL:
            begin
               next_pwm_input_control = reg_wdata;
               // an invalid hysteresis code is refused, old setting kept
               if (reg_wdata[PWM_HYST_HI:PWM_HYST_LO] == HYST_INVALID)
                  next_pwm_input_control[PWM_HYST_HI:PWM_HYST_LO] =
                     pwm_input_control[PWM_HYST_HI:PWM_HYST_LO];
            end
            OFS_BOOST_CTRL: next_boost_converter_control = reg_wdata & BOOST_CTRL_WMASK;
            OFS_AF_UPPER: next_auto_freq_upper_threshold = reg_wdata;
            OFS_AF_LOWER: next_auto_freq_lower_threshold = reg_wdata;
            OFS_CEILING: next_brightness_ceiling = reg_wdata;
            OFS_CODE_LOW: next_brightness_code_low = reg_wdata[CODE_LOW_W-1:0];
            OFS_CODE_HIGH: next_brightness_code_high = reg_wdata;
            OFS_FAULT_CTRL: next_fault_response_control = reg_wdata[FAULT_CTRL_W-1:0];
            default: ;
         endcase
      end
      // enable restore beats a same-cycle write
      if (enable_rise)
         next_pwm_input_control = PWM_CTRL_RST;

      if (next_pwm_input_control[PWM_RATE_HI])
         next_pwm_sample_rate = RATE_24M;
      else if (next_pwm_input_control[PWM_RATE_LO])
         next_pwm_sample_rate = RATE_4M;
      else
         next_pwm_sample_rate = RATE_800K;

      next_reg_rdata = reg_read ? readback(reg_addr) : reg_rdata;

      // a new enable edge is needed after a shutdown; a pending shutdown refuses it
      next_fault_shutdown = link.shutdown;
      if (!device_enable || link.shutdown)
         next_device_running = 1'b0;
      else if (enable_rise)
         next_device_running = 1'b1;
      else
         next_device_running = device_running;
   end

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         pwm_input_control <= PWM_CTRL_RST;
         boost_converter_control <= BOOST_CTRL_RST;
         auto_freq_upper_threshold <= AF_UPPER_RST;
         auto_freq_lower_threshold <= AF_LOWER_RST;
         brightness_ceiling <= CEILING_RST;
         brightness_code_low <= CODE_LOW_RST;
         brightness_code_high <= CODE_HIGH_RST;
         fault_response_control <= FAULT_CTRL_RST;
         pwm_sample_rate <= RATE_4M;
         reg_rdata <= READ_ZERO;
         enable_seen <= 1'b0;
         device_running <= 1'b0;
         fault_shutdown <= 1'b0;
      end
      else
      begin
         pwm_input_control <= next_pwm_input_control;
         boost_converter_control <= next_boost_converter_control;
         auto_freq_upper_threshold <= next_auto_freq_upper_threshold;
         auto_freq_lower_threshold <= next_auto_freq_lower_threshold;
         brightness_ceiling <= next_brightness_ceiling;
         brightness_code_low <= next_brightness_code_low;
         brightness_code_high <= next_brightness_code_high;
         fault_response_control <= next_fault_response_control;
         pwm_sample_rate <= next_pwm_sample_rate;
         reg_rdata <= next_reg_rdata;
         enable_seen <= device_enable;
         device_running <= next_device_running;
         fault_shutdown <= next_fault_shutdown;
      end
   end

   // settings leave straight from the register flops
   assign pwm_active_high = pwm_input_control[PWM_POL_BIT];
   assign pwm_hysteresis_steps = pwm_input_control[PWM_HYST_HI:PWM_HYST_LO];
   assign pwm_filter_sel = pwm_input_control[PWM_FILT_HI:PWM_FILT_LO];
   assign boost_no_shift = boost_converter_control[BOOST_SHIFT_BIT];
   assign boost_freq_1mhz = boost_converter_control[BOOST_FREQ_BIT];
   assign inductor_22uh = boost_converter_control[BOOST_IND_BIT];
   assign overvoltage_level = boost_converter_control[BOOST_OVP_HI:BOOST_OVP_LO];
   assign current_limit_level = boost_converter_control[BOOST_ILIM_HI:BOOST_ILIM_LO];
endmodule : backlight_driver_config_regs
`default_nettype wire

//--- verification/backlight_cfg_checker.sv
`timescale 1ns/1ps
`default_nettype none
module backlight_cfg_checker (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // register port
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [backlight_cfg_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [backlight_cfg_pkg::DATA_W-1:0] reg_wdata,
   input wire logic [backlight_cfg_pkg::DATA_W-1:0] reg_rdata,
   // run state and ceiling pin
   input wire logic device_enable,
   input wire logic device_running,
   input wire logic fault_shutdown,
   input wire logic brightness_ceiling_input,
   // settings and code
   input wire backlight_cfg_pkg::sample_rate_t pwm_sample_rate,
   input wire logic pwm_active_high,
   input wire logic [2:0] pwm_hysteresis_steps,
   input wire logic [1:0] pwm_filter_sel,
   input wire logic boost_no_shift,
   input wire logic boost_freq_1mhz,
   input wire logic inductor_22uh,
   input wire logic [1:0] overvoltage_level,
   input wire logic [1:0] current_limit_level,
   input wire logic [backlight_cfg_pkg::CODE_W-1:0] brightness_code
);
   import backlight_cfg_pkg::*;
   logic enable_q;
   logic pwm_wr;
   logic unmapped;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!resetn);
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         enable_q <= 1'b0;
      else
         enable_q <= device_enable;
   end
   // an enable rise overrides a write in the same cycle
   assign pwm_wr = reg_write && reg_addr == OFS_PWM_CTRL && !(device_enable && !enable_q);
   assign unmapped = reg_addr < 8'h12 || reg_addr == 8'h14 ||
      (reg_addr > 8'h19 && reg_addr < 8'h1e) || reg_addr > 8'h1f;
   a_rate_decode: assert property (pwm_wr |=> pwm_sample_rate ==
      ($past(reg_wdata[7]) ? RATE_24M : ($past(reg_wdata[6]) ? RATE_4M : RATE_800K))) else $error("rate mismatch");
   a_pwm_fields: assert property (pwm_wr |=> pwm_active_high == $past(reg_wdata[5]) &&
      pwm_filter_sel == $past(reg_wdata[1:0])) else $error("pwm field mismatch");
   a_hyst_taken: assert property (pwm_wr && reg_wdata[4:2] != HYST_INVALID |=>
      pwm_hysteresis_steps == $past(reg_wdata[4:2])) else $error("hysteresis not taken");
   a_hyst_refused: assert property (pwm_wr && reg_wdata[4:2] == HYST_INVALID |=>
      $stable(pwm_hysteresis_steps)) else $error("invalid hysteresis taken");
   a_enable_restore: assert property (device_enable && !enable_q |=> pwm_sample_rate == RATE_4M &&
      pwm_active_high && pwm_hysteresis_steps == 3'h4 && pwm_filter_sel == 2'h3) else $error("pwm not restored");
   a_boost_fields: assert property (reg_write && reg_addr == OFS_BOOST_CTRL |=>
      {boost_no_shift, boost_freq_1mhz, inductor_22uh, overvoltage_level, current_limit_level}
      == $past(reg_wdata[6:0])) else $error("boost field mismatch");
   a_code_upper: assert property ((reg_write && reg_addr == OFS_CODE_HIGH && !brightness_ceiling_input)
      ##1 !brightness_ceiling_input |=> brightness_code[10:3] == $past(reg_wdata, 2)) else $error("code upper bad");
   a_unmapped_zero: assert property (reg_read && unmapped |=> reg_rdata == READ_ZERO)
      else $error("unmapped read not zero");
   a_low_reserved: assert property (reg_read && reg_addr == OFS_CODE_LOW |=> reg_rdata[7:3] == 5'h00)
      else $error("low code reserved bits set");
   a_flags_reserved: assert property (reg_read && reg_addr == OFS_FAULT_FLAGS |=> reg_rdata[7:5] == 3'h0)
      else $error("flag reserved bits set");
   a_shutdown_stops: assert property (fault_shutdown |-> !device_running)
      else $error("running during shutdown");
   a_running_start: assert property ($rose(device_running) |-> $past(device_enable) && !$past(enable_q))
      else $error("run started without enable rise");
endmodule : backlight_cfg_checker
bind backlight_driver_config_regs backlight_cfg_checker u_backlight_cfg_checker (.clock, .resetn, .reg_write,
   .reg_read, .reg_addr, .reg_wdata, .reg_rdata, .device_enable, .device_running, .fault_shutdown,
   .brightness_ceiling_input, .pwm_sample_rate, .pwm_active_high, .pwm_hysteresis_steps, .pwm_filter_sel,
   .boost_no_shift, .boost_freq_1mhz, .inductor_22uh, .overvoltage_level, .current_limit_level, .brightness_code);
`default_nettype wire

//--- verification/serial_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
   // clock
   input wire logic clock,
   // register strobes
   output logic reg_write,
   output logic reg_read,
   output logic [backlight_cfg_pkg::ADDR_W-1:0] reg_addr,
   output logic [backlight_cfg_pkg::DATA_W-1:0] reg_wdata,
   input wire logic [backlight_cfg_pkg::DATA_W-1:0] reg_rdata
);
   import backlight_cfg_pkg::*;
   initial
   begin
      reg_write = 1'b0;
      reg_read = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end
   // idle lines show the inverse of the last value so stale data never looks valid
   task automatic access(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                         output logic [DATA_W-1:0] q);
      @(posedge clock);
      #1;
      reg_write = wr;
      reg_read = !wr;
      reg_addr = a;
      reg_wdata = d;
      @(posedge clock);
      #1;
      q = reg_rdata;
      reg_write = 1'b0;
      reg_read = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask : access
endmodule : serial_host_model
`default_nettype wire

//--- verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import backlight_cfg_pkg::*;
   logic clock, resetn, device_enable, brightness_ceiling_input, reg_write, reg_read;
   logic device_running, fault_shutdown, pwm_active_high, boost_no_shift, boost_freq_1mhz, inductor_22uh;
   logic [4:0] det;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic [2:0] pwm_hysteresis_steps;
   logic [1:0] pwm_filter_sel, overvoltage_level, current_limit_level;
   logic [10:0] brightness_code;
   logic [6:0] bv;
   sample_rate_t pwm_sample_rate;
   switch_freq_t auto_freq_sel;
   int bad_count = 0;
   int total_checks = 0;
   logic [7:0] addrs [12] = '{8'h12, 8'h13, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1e, 8'h1f, 8'h14, 8'h00, 8'h20};
   logic [7:0] rsts [12] = '{8'h73, 8'h6f, 8'h00, 8'h00, 8'h00, 8'h07, 8'hff, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [7:0] ceil_v [4] = '{8'h3c, 8'h40, 8'h7f, 8'h80};
   switch_freq_t freq_v [4] = '{FREQ_250K, FREQ_500K, FREQ_500K, FREQ_1000K};
   int trip [4] = '{0, 1, 2, 4};
   backlight_driver_config_regs u_backlight_driver_config_regs (.clock, .resetn, .reg_write, .reg_read,
      .reg_addr, .reg_wdata, .reg_rdata, .device_enable, .device_running, .fault_shutdown,
      .output_overvoltage_protect(det[0]), .switch_current_limit(det[1]), .thermal_shutdown(det[2]),
      .led_short_detect(det[3]), .led_open_detect(det[4]), .brightness_ceiling_input, .pwm_sample_rate,
      .pwm_active_high, .pwm_hysteresis_steps, .pwm_filter_sel, .boost_no_shift, .boost_freq_1mhz,
      .inductor_22uh, .overvoltage_level, .current_limit_level, .brightness_code, .auto_freq_sel);
   serial_host_model u_serial_host_model (.clock, .reg_write, .reg_read, .reg_addr, .reg_wdata, .reg_rdata);
   task automatic check(input string what, input logic [10:0] seen, input logic [10:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : tick
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      u_serial_host_model.access(1'b1, a, d, q);
   endtask : wr
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] q;
      u_serial_host_model.access(1'b0, a, 8'h00, q);
      check($sformatf("reg %h", a), 11'(q), 11'(e));
   endtask : rdchk
   task automatic reenable();
      device_enable = 1'b0;
      tick(1);
      device_enable = 1'b1;
      tick(2);
   endtask : reenable
   task automatic pulse(input logic [4:0] v);
      det = v;
      tick(1);
      det = 5'h00;
      tick(2);
   endtask : pulse
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : conclude
   initial
   begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   // whole sequence needs under a tenth of this
   initial
   begin
      #100000;
      bad_count++;
      conclude();
   end
   initial
   begin
      resetn = 1'b0;
      device_enable = 1'b0;
      brightness_ceiling_input = 1'b0;
      det = 5'h00;
      tick(2);
      resetn = 1'b1;
      for (int i = 0; i < 12; i++)
         rdchk(addrs[i], rsts[i]);
      check("rate", 11'(pwm_sample_rate), 11'(RATE_4M));
      check("code", brightness_code, 11'h7ff);
      $display("test reset done");
      for (int i = 0; i < 4; i++)
      begin
         wr(OFS_PWM_CTRL, {2'(i), i[0], 3'(2 * i), 2'(3 - i)});
         check("rate", 11'(pwm_sample_rate), 11'((i == 0) ? RATE_800K : (i == 1) ? RATE_4M : RATE_24M));
         check("polarity", 11'(pwm_active_high), 11'(i[0]));
         check("hyst", 11'(pwm_hysteresis_steps), 11'(2 * i));
         check("filter", 11'(pwm_filter_sel), 11'(3 - i));
      end
      wr(OFS_PWM_CTRL, 8'h1c);
      rdchk(OFS_PWM_CTRL, 8'h18);
      reenable();
      rdchk(OFS_PWM_CTRL, 8'h73);
      $display("test pwm done");
      for (int j = 0; j < 4; j++)
      begin
         bv = {j[0], j[1], j[0], 2'(j), 2'(3 - j)};
         wr(OFS_BOOST_CTRL, {1'b1, bv});
         check("boost", 11'({boost_no_shift, boost_freq_1mhz, inductor_22uh, overvoltage_level,
            current_limit_level}), 11'(bv));
         rdchk(OFS_BOOST_CTRL, {1'b0, bv});
      end
      $display("test boost done");
      wr(OFS_CODE_HIGH, 8'ha5);
      wr(OFS_CODE_LOW, 8'hfe);
      rdchk(OFS_CODE_LOW, 8'h06);
      rdchk(OFS_CODE_HIGH, 8'ha5);
      check("code", brightness_code, {8'ha5, 3'h6});
      wr(OFS_AF_UPPER, 8'h80);
      wr(OFS_AF_LOWER, 8'h40);
      rdchk(OFS_AF_UPPER, 8'h80);
      rdchk(OFS_AF_LOWER, 8'h40);
      check("freq", 11'(auto_freq_sel), 11'(FREQ_1000K));
      brightness_ceiling_input = 1'b1;
      for (int k = 0; k < 4; k++)
      begin
         wr(OFS_CEILING, ceil_v[k]);
         tick(2);
         check("code", brightness_code, {ceil_v[k], 3'h6});
         check("freq", 11'(auto_freq_sel), 11'(freq_v[k]));
      end
      brightness_ceiling_input = 1'b0;
      tick(2);
      check("code", brightness_code, {8'ha5, 3'h6});
      $display("test brightness done");
      for (int k = 0; k < 4; k++)
      begin
         wr(OFS_FAULT_CTRL, 8'h08);
         reenable();
         pulse(5'(1 << trip[k]));
         check("shutdown", 11'(fault_shutdown), 11'h1);
         check("running", 11'(device_running), 11'h0);
         reenable();
         check("running", 11'(device_running), 11'h0);
         rdchk(OFS_FAULT_FLAGS, 8'(1 << trip[k]));
         reenable();
         check("running", 11'(device_running), 11'h1);
         rdchk(OFS_FAULT_FLAGS, 8'h00);
      end
      wr(OFS_FAULT_CTRL, 8'hff);
      rdchk(OFS_FAULT_CTRL, 8'h0f);
      pulse(5'h0a);
      check("running", 11'(device_running), 11'h1);
      rdchk(OFS_FAULT_FLAGS, 8'h0a);
      wr(OFS_FAULT_CTRL, 8'h07);
      pulse(5'h08);
      wr(OFS_FAULT_FLAGS, 8'hff);
      rdchk(OFS_FAULT_FLAGS, 8'h00);
      $display("test faults done");
      conclude();
   end
endmodule : testbench
`default_nettype wire
